// ===== core/twbm_regs.vh
// Constants shared by the two-wire bus master core and its helpers.
// Assumes a single 100 MHz system clock and open-drain pads outside the core.
//
// How it works
// R1: Every byte is 8 bits, MSB first, followed by one acknowledge slot.
// R2: Any number of bytes may pass between START and STOP.
// R3: START is data falling while clock stays high.
// R4: STOP is data rising while clock stays high.
// R5: Every transfer opens with START and closes with STOP.
// R6: Lines are only pulled low or released; released lines float high.
// R7: The master makes the serial clock from the programmed waveform settings.
// R8: A holding write in write mode sends START, address, direction 0.
// R9: On the ninth pulse the transmitter releases data for the acknowledge.
// R10: A high data line at the acknowledge sets the sticky no-ack flag.
// R11: After an acknowledged byte the holding byte moves to the shifter.
// R12: Acknowledge sets transmit-ready; it stays until the next holding write.
// R13: With no further holding byte the master sends STOP itself.
// R14: Transfer-complete is set once the closing STOP has finished.
// R15: The start command in read mode sends START, address, direction 1.
// R16: Received bytes are acknowledged except the last, which is followed by STOP.
// R17: A received byte fills receive holding and sets receive-ready until read.
// R18: Software sets start and stop together for a single-byte read.
// R19: Software issues stop after the next-to-last byte of a longer read.
// R20: Reads with internal address write it first, then repeated START.
// R21: Software picks 0 to 3 internal address bytes, 0 for none.
// R22: For 10-bit slaves software uses one address byte and 11110 prefix.
// R23: Each clock phase lasts divider times two to the exponent, plus 3.
// R24: A no-ack during a read makes the master send STOP.
// R25: Address size codes 00, 01, 10, 11 mean 0 to 3 bytes.
// R26: Data changes only while clock is low and is sampled while high.
// R27: Internal address bytes go MSB first after the address byte.
`ifndef TWBM_REGS_VH
`define TWBM_REGS_VH

`define TWBM_LAST_DATA_BIT 4'd7
`define TWBM_ACK_SLOT      4'd8
`define TWBM_PHASE_EXTRA   3
`define TWBM_WRITE_DIR     1'b0
`define TWBM_READ_DIR      1'b1
`define TWBM_LINE_IDLE     1'b1
`define TWBM_INTERNAL_ADDRESS_VALUE_NONE     2'b00
`define TWBM_INTERNAL_ADDRESS_VALUE_ONE      2'b01
`define TWBM_INTERNAL_ADDRESS_VALUE_TWO      2'b10
`define TWBM_INTERNAL_ADDRESS_VALUE_THREE    2'b11
`define TWBM_TX_HOLDING_READY_RST     1'b1
`define TWBM_TRANSFER_COMPLETE_FLAG_RST    1'b1
`define TWBM_ENABLE_RST    1'b0

`endif

// ===== core/twbm_sync.v
// Two-stage synchroniser for the sensed levels of the bus lines.
// Assumes the inputs are asynchronous pad levels; idle level is high.
`timescale 1ns/1ns
`include "twbm_regs.vh"

module twbm_sync #(
   parameter W = 2
) (
   input  wire         sys_clk_i,
   input  wire         reset_n_i,
   input  wire [W-1:0] async_i,
   output reg  [W-1:0] sync_o
);

   reg [W-1:0] meta;

   always @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         meta   <= {W{`TWBM_LINE_IDLE}};
         sync_o <= {W{`TWBM_LINE_IDLE}};
      end else begin
         meta   <= async_i;
         sync_o <= meta;
      end
   end

endmodule

// ===== core/twbm_phase.v
// Serial clock phase timer: counts one low or high phase of the bus clock.
// Assumes run drops or done fires between phases so each phase starts at zero.
`timescale 1ns/1ns
`include "twbm_regs.vh"

module twbm_phase #(
   parameter DIV_W = 8,
   parameter EXP_W = 3,
   parameter CNT_W = 16
) (
   input  wire             sys_clk_i,
   input  wire             reset_n_i,
   input  wire             run_i,
   input  wire             use_high_i,
   input  wire [DIV_W-1:0] low_div_i,
   input  wire [DIV_W-1:0] high_div_i,
   input  wire [EXP_W-1:0] exp_i,
   output wire             done_o
);

   reg  [CNT_W-1:0] count;
   wire [DIV_W-1:0] div_sel = use_high_i ? high_div_i : low_div_i;
   wire [CNT_W-1:0] scaled  = {{(CNT_W-DIV_W){1'b0}}, div_sel} << exp_i;
   wire [31:0]      extra   = `TWBM_PHASE_EXTRA;
   wire [CNT_W-1:0] target  = scaled + extra[CNT_W-1:0]; // [R23]

   assign done_o = run_i && (count == target - 1'b1);

   always @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         count <= {CNT_W{1'b0}};
      end else if (!run_i || done_o) begin
         count <= {CNT_W{1'b0}};
      end else begin
         count <= count + 1'b1;
      end
   end

endmodule

// ===== core/twbm_master.v
// Two-wire bus master: start/stop generation, address, internal address,
// byte transmit and receive with acknowledge, and status flags.
// Assumes open-drain pads outside; command and holding strobes come from
// logic on sys_clk_i and are one-cycle pulses.
`timescale 1ns/1ns
`include "twbm_regs.vh"

module twbm_master #(
   parameter DIV_W = 8,
   parameter EXP_W = 3,
   parameter CNT_W = 16
) (
   input  wire             sys_clk_i,
   input  wire             reset_n_i,
   input  wire             soft_reset_i,
   input  wire             master_enable_i,
   input  wire             master_disable_i,
   input  wire             start_cmd_i,
   input  wire             stop_cmd_i,
   input  wire             read_direction_select_i,
   input  wire [6:0]       device_address_field_i,
   input  wire [1:0]       internal_address_size_i,
   input  wire [23:0]      internal_address_value_i,
   input  wire [DIV_W-1:0] low_phase_divider_i,
   input  wire [DIV_W-1:0] high_phase_divider_i,
   input  wire [EXP_W-1:0] phase_prescale_exponent_i,
   input  wire             transmit_holding_wr_i,
   input  wire [7:0]       transmit_holding_i,
   input  wire             receive_holding_rd_i,
   input  wire             serial_clock_line_i,
   input  wire             serial_data_line_i,
   output reg              serial_clock_line_o,
   output reg              serial_clock_line_oe_o,
   output reg              serial_data_line_o,
   output reg              serial_data_line_oe_o,
   output reg  [7:0]       receive_holding_o,
   output reg              no_ack_flag_o,
   output reg              tx_holding_ready_o,
   output reg              rx_holding_ready_o,
   output reg              transfer_complete_flag_o
);

   localparam [3:0] ST_IDLE      = 4'd0;
   localparam [3:0] ST_SETUP     = 4'd1;
   localparam [3:0] ST_START     = 4'd2;
   localparam [3:0] ST_LOW       = 4'd3;
   localparam [3:0] ST_HIGH      = 4'd4;
   localparam [3:0] ST_STOP_LOW  = 4'd5;
   localparam [3:0] ST_STOP_HIGH = 4'd6;
   localparam [3:0] ST_STOP_END  = 4'd7;
   localparam [3:0] ST_RS_LOW    = 4'd8;

   localparam [1:0] PH_ADDR = 2'd0;
   localparam [1:0] PH_INTERNAL_ADDRESS_VALUE = 2'd1;
   localparam [1:0] PH_TX   = 2'd2;
   localparam [1:0] PH_RX   = 2'd3;

   reg  [3:0] state;
   reg  [1:0] phase;
   reg  [3:0] bit_cnt;
   reg  [7:0] shifter;
   reg  [7:0] holding;
   reg        hold_full;
   reg        rd_mode;
   reg        addr_rd;
   reg  [1:0] internal_address_value_left;
   reg  [23:0] internal_address_value_val;
   reg        stop_pend;
   reg        enabled;

   wire [1:0] lines_s;
   wire       scl_s = lines_s[1];
   wire       sda_s = lines_s[0];
   wire       phase_done;
   wire       timer_run;
   wire       high_state;
   wire       ack_ok = ~sda_s;
   wire       sda_want;

   // Selects one internal address byte, the highest remaining first.
   function [7:0] internal_address_value_byte;
      input [23:0] v;
      input [1:0]  n;
      begin
         case (n)
            `TWBM_INTERNAL_ADDRESS_VALUE_THREE: internal_address_value_byte = v[23:16];
            `TWBM_INTERNAL_ADDRESS_VALUE_TWO:   internal_address_value_byte = v[15:8];
            default:          internal_address_value_byte = v[7:0];
         endcase
      end
   endfunction

   // States in which the master holds the serial clock low.
   function is_low_state;
      input [3:0] s;
      begin
         is_low_state = (s == ST_LOW) || (s == ST_STOP_LOW) || (s == ST_RS_LOW);
      end
   endfunction

   twbm_sync #(
      .W (2)
   ) u_sync (
      .sys_clk_i (sys_clk_i),
      .reset_n_i (reset_n_i),
      .async_i   ({serial_clock_line_i, serial_data_line_i}),
      .sync_o    (lines_s)
   );

   // High phases only count while the line is really high, which also
   // lets a slave stretch the clock.
   assign high_state = (state == ST_SETUP) || (state == ST_START) ||
                       (state == ST_HIGH) || (state == ST_STOP_HIGH) ||
                       (state == ST_STOP_END);
   assign timer_run  = is_low_state(state) || (high_state && scl_s); // [R7]

   twbm_phase #(
      .DIV_W (DIV_W),
      .EXP_W (EXP_W),
      .CNT_W (CNT_W)
   ) u_phase (
      .sys_clk_i  (sys_clk_i),
      .reset_n_i  (reset_n_i),
      .run_i      (timer_run),
      .use_high_i (high_state),
      .low_div_i  (low_phase_divider_i),
      .high_div_i (high_phase_divider_i),
      .exp_i      (phase_prescale_exponent_i),
      .done_o     (phase_done)
   );

   // Data pulled low for a 0 bit or for the master's own acknowledge.
   assign sda_want = (bit_cnt == `TWBM_ACK_SLOT) ?
                     ((phase == PH_RX) && !stop_pend) :       // [R16]
                     ((phase != PH_RX) && !shifter[7]);       // [R1]

   // Open-drain pads: output value is always low, only the enable moves.
   always @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         serial_clock_line_o    <= 1'b0;
         serial_data_line_o     <= 1'b0;
         serial_clock_line_oe_o <= 1'b0;
         serial_data_line_oe_o  <= 1'b0;
      end else if (soft_reset_i) begin
         serial_clock_line_o    <= 1'b0;
         serial_data_line_o     <= 1'b0;
         serial_clock_line_oe_o <= 1'b0;
         serial_data_line_oe_o  <= 1'b0;
      end else begin
         serial_clock_line_o    <= 1'b0; // [R6]
         serial_data_line_o     <= 1'b0; // [R6]
         serial_clock_line_oe_o <= is_low_state(state);
         case (state)
            ST_START, ST_STOP_HIGH: begin
               serial_data_line_oe_o <= 1'b1; // [R3] [R4]
            end
            ST_LOW: begin
               // Data moves only once the clock is already held low.
               if (serial_clock_line_oe_o) begin
                  serial_data_line_oe_o <= sda_want; // [R26] [R9]
               end
            end
            ST_STOP_LOW: begin
               if (serial_clock_line_oe_o) begin
                  serial_data_line_oe_o <= 1'b1;
               end
            end
            ST_RS_LOW: begin
               if (serial_clock_line_oe_o) begin
                  serial_data_line_oe_o <= 1'b0;
               end
            end
            ST_IDLE, ST_SETUP, ST_STOP_END: begin
               serial_data_line_oe_o <= 1'b0;
            end
            default: begin
               serial_data_line_oe_o <= serial_data_line_oe_o;
            end
         endcase
      end
   end

   always @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state                    <= ST_IDLE;
         phase                    <= PH_ADDR;
         bit_cnt                  <= 4'd0;
         shifter                  <= 8'h00;
         holding                  <= 8'h00;
         hold_full                <= 1'b0;
         rd_mode                  <= 1'b0;
         addr_rd                  <= 1'b0;
         internal_address_value_left                <= `TWBM_INTERNAL_ADDRESS_VALUE_NONE;
         internal_address_value_val                 <= 24'h000000;
         stop_pend                <= 1'b0;
         enabled                  <= `TWBM_ENABLE_RST;
         receive_holding_o        <= 8'h00;
         no_ack_flag_o            <= 1'b0;
         tx_holding_ready_o       <= `TWBM_TX_HOLDING_READY_RST;
         rx_holding_ready_o       <= 1'b0;
         transfer_complete_flag_o <= `TWBM_TRANSFER_COMPLETE_FLAG_RST;
      end else if (soft_reset_i) begin
         state                    <= ST_IDLE;
         phase                    <= PH_ADDR;
         bit_cnt                  <= 4'd0;
         shifter                  <= 8'h00;
         holding                  <= 8'h00;
         hold_full                <= 1'b0;
         rd_mode                  <= 1'b0;
         addr_rd                  <= 1'b0;
         internal_address_value_left                <= `TWBM_INTERNAL_ADDRESS_VALUE_NONE;
         internal_address_value_val                 <= 24'h000000;
         stop_pend                <= 1'b0;
         enabled                  <= `TWBM_ENABLE_RST;
         receive_holding_o        <= 8'h00;
         no_ack_flag_o            <= 1'b0;
         tx_holding_ready_o       <= `TWBM_TX_HOLDING_READY_RST;
         rx_holding_ready_o       <= 1'b0;
         transfer_complete_flag_o <= `TWBM_TRANSFER_COMPLETE_FLAG_RST;
      end else begin
         if (master_enable_i && !master_disable_i) begin
            enabled                  <= 1'b1;
            transfer_complete_flag_o <= 1'b1;
         end else if (master_disable_i) begin
            enabled <= 1'b0;
         end
         if (stop_cmd_i) begin
            stop_pend <= 1'b1;
         end
         if (receive_holding_rd_i) begin
            rx_holding_ready_o <= 1'b0;
         end

         case (state)
            ST_IDLE: begin
               bit_cnt <= 4'd0;
               if (enabled && ((!read_direction_select_i && hold_full) ||
                               (read_direction_select_i && start_cmd_i))) begin
                  // [R8] [R15] [R20] A read with internal address opens in write direction.
                  addr_rd   <= read_direction_select_i &&
                               (internal_address_size_i == `TWBM_INTERNAL_ADDRESS_VALUE_NONE);
                  shifter   <= {device_address_field_i,
                                read_direction_select_i &&
                                (internal_address_size_i == `TWBM_INTERNAL_ADDRESS_VALUE_NONE)};
                  rd_mode   <= read_direction_select_i;
                  internal_address_value_left <= internal_address_size_i; // [R25]
                  internal_address_value_val  <= internal_address_value_i;
                  stop_pend <= stop_cmd_i;
                  phase     <= PH_ADDR;
                  no_ack_flag_o            <= 1'b0;
                  transfer_complete_flag_o <= 1'b0;
                  state     <= ST_SETUP; // [R5]
               end
            end

            ST_SETUP: begin
               if (phase_done) begin
                  state <= ST_START;
               end
            end

            ST_START: begin
               if (phase_done) begin
                  bit_cnt <= 4'd0;
                  state   <= ST_LOW; // [R3]
               end
            end

            ST_LOW: begin
               if (phase_done) begin
                  state <= ST_HIGH;
               end
            end

            ST_HIGH: begin
               if (phase_done && bit_cnt != `TWBM_ACK_SLOT) begin
                  // Sampled at the end of the high phase, MSB first.
                  shifter <= {shifter[6:0], sda_s}; // [R26] [R1]
                  bit_cnt <= bit_cnt + 1'b1;
                  state   <= ST_LOW;
                  if (phase == PH_RX && bit_cnt == `TWBM_LAST_DATA_BIT) begin
                     receive_holding_o  <= {shifter[6:0], sda_s}; // [R17]
                     rx_holding_ready_o <= 1'b1;                  // [R17]
                  end
               end else if (phase_done) begin
                  bit_cnt <= 4'd0;
                  state   <= ST_LOW;
                  if (phase == PH_RX) begin
                     // Own acknowledge driven: keep reading; otherwise stop.
                     if (!serial_data_line_oe_o) begin
                        state <= ST_STOP_LOW; // [R16] [R2]
                     end
                  end else if (!ack_ok) begin
                     // A waiting holding byte is dropped so that no new START follows without a write.
                     no_ack_flag_o <= 1'b1;       // [R10]
                     hold_full     <= 1'b0;       // [R8]
                     state         <= ST_STOP_LOW; // [R24]
                  end else if (internal_address_value_left != `TWBM_INTERNAL_ADDRESS_VALUE_NONE && phase != PH_TX) begin
                     shifter   <= internal_address_value_byte(internal_address_value_val, internal_address_value_left); // [R27]
                     internal_address_value_left <= internal_address_value_left - 1'b1;
                     phase     <= PH_INTERNAL_ADDRESS_VALUE;
                  end else if (rd_mode && addr_rd) begin
                     phase <= PH_RX;
                  end else if (rd_mode) begin
                     shifter <= {device_address_field_i, `TWBM_READ_DIR};
                     addr_rd <= 1'b1;
                     phase   <= PH_ADDR;
                     state   <= ST_RS_LOW; // [R20]
                  end else begin
                     tx_holding_ready_o <= 1'b1; // [R12]
                     if (hold_full) begin
                        shifter   <= holding; // [R11]
                        hold_full <= 1'b0;
                        phase     <= PH_TX;
                     end else begin
                        state <= ST_STOP_LOW; // [R13]
                     end
                  end
               end
            end

            ST_RS_LOW: begin
               if (phase_done) begin
                  state <= ST_SETUP;
               end
            end

            ST_STOP_LOW: begin
               if (phase_done) begin
                  state <= ST_STOP_HIGH;
               end
            end

            ST_STOP_HIGH: begin
               if (phase_done) begin
                  state <= ST_STOP_END; // [R4]
               end
            end

            ST_STOP_END: begin
               if (phase_done) begin
                  stop_pend                <= stop_cmd_i;
                  transfer_complete_flag_o <= 1'b1; // [R14] [R5]
                  state                    <= ST_IDLE;
               end
            end

            default: begin
               state <= ST_IDLE;
            end
         endcase

         // A new holding byte wins over a move taken in the same cycle.
         if (transmit_holding_wr_i) begin
            holding            <= transmit_holding_i;
            hold_full          <= 1'b1;
            tx_holding_ready_o <= 1'b0; // [R12]
         end
      end
   end

endmodule

// ===== tb/twbm_master_asserts.sv
// Port checker for the two-wire bus master.
// Assumes phase settings that give 7 cycles per serial clock phase.
`timescale 1ns/1ns
module twbm_chk (
   input wire sys_clk_i,
   input wire reset_n_i,
   input wire soft_reset_i,
   input wire transmit_holding_wr_i,
   input wire receive_holding_rd_i,
   input wire serial_clock_line_o,
   input wire serial_clock_line_oe_o,
   input wire serial_data_line_o,
   input wire serial_data_line_oe_o,
   input wire rx_holding_ready_o,
   input wire tx_holding_ready_o,
   input wire transfer_complete_flag_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!reset_n_i);
   chk_pins_pull_low: assert property (!serial_clock_line_o && !serial_data_line_o)
      else $error("line driven high");
   chk_start_when_busy: assert property ($rose(serial_data_line_oe_o) &&
      !serial_clock_line_oe_o |-> !transfer_complete_flag_o) else $error("start while idle");
   chk_stop_then_done: assert property ($fell(serial_data_line_oe_o) &&
      !serial_clock_line_oe_o |-> ##[1:40] transfer_complete_flag_o) else $error("stop no done");
   chk_done_lines_free: assert property ($rose(transfer_complete_flag_o) |->
      !serial_data_line_oe_o && !serial_clock_line_oe_o) else $error("done with bus held");
   chk_low_phase_len: assert property ($rose(serial_clock_line_oe_o) |->
      serial_clock_line_oe_o[*7]) else $error("low phase short");
   chk_high_phase_len: assert property ($fell(serial_clock_line_oe_o) |->
      !serial_clock_line_oe_o[*7]) else $error("high phase short");
   chk_tx_ready_kept: assert property (tx_holding_ready_o && !transmit_holding_wr_i &&
      !soft_reset_i |=> tx_holding_ready_o) else $error("tx ready lost");
   chk_tx_ready_drop: assert property (transmit_holding_wr_i |=>
      !tx_holding_ready_o) else $error("tx ready kept after write");
   chk_rx_ready_kept: assert property (rx_holding_ready_o && !receive_holding_rd_i &&
      !soft_reset_i |=> rx_holding_ready_o) else $error("rx ready lost");
   chk_rx_read_clear: assert property (receive_holding_rd_i &&
      transfer_complete_flag_o |=> !rx_holding_ready_o) else $error("rx ready not cleared");
endmodule

// ===== tb/twbm_slave_model.sv
// Behavioural bus slave: acknowledges its own address and every written byte,
// returns an incrementing byte stream on reads and logs each byte it receives.
// Assumes a pull-up outside; the model only ever pulls the data line low.
`timescale 1ns/1ns
module twbm_slave_model (
   input  wire       scl_i,
   input  wire       sda_i,
   input  wire [6:0] dev_addr_i,
   input  wire [7:0] rd_base_i,
   output reg        sda_oe_o = 1'b0
);
   reg [7:0] sh;
   reg [7:0] tx;
   reg [7:0] wr_log [0:15];
   reg       act = 1'b0;
   reg       adr = 1'b0;
   reg       rd = 1'b0;
   reg       mack = 1'b0;
   integer   cnt = 0, n_wr = 0, n_rd = 0, n_start = 0, n_stop = 0;
   always @(negedge sda_i) if (scl_i) begin
      act = 1'b1;
      adr = 1'b1;
      rd = 1'b0;
      cnt = 0;
      n_start = n_start + 1;
   end
   always @(posedge sda_i) if (scl_i && act) begin
      act = 1'b0;
      n_stop = n_stop + 1;
   end
   always @(posedge scl_i) if (act) begin
      if (cnt < 8) sh = {sh[6:0], sda_i};
      else mack = !sda_i;
      cnt = cnt + 1;
   end
   always @(negedge scl_i) if (act) begin
      sda_oe_o = 1'b0;
      if (cnt == 9) begin
         cnt = 0;
         if (rd && (adr || mack)) begin
            tx = rd_base_i + n_rd[7:0];
            n_rd = n_rd + 1;
         end else rd = 1'b0;
         adr = 1'b0;
      end
      if (cnt == 8 && !rd) begin
         wr_log[n_wr[3:0]] = sh;
         n_wr = n_wr + 1;
         rd = adr && sh[0] && sh[7:1] == dev_addr_i;
         sda_oe_o = !adr || sh[7:1] == dev_addr_i;
      end
      if (rd && !adr && cnt < 8) sda_oe_o = !tx[7 - cnt];
   end
endmodule

// ===== tb/tb_twbm_master.sv
// Self-checking bench for the two-wire bus master against a slave model.
// Assumes the checker and the slave model files are compiled first.
`timescale 1ns/1ns
`define CHK(nm, e, a) begin n_checks = n_checks + 1; \
   if ((a) !== (e)) begin n_errors = n_errors + 1; \
   $display("[ERR] %s exp %h got %h", nm, e, a); end end
module tb_twbm_master;
   reg         sys_clk_i = 1'b0;
   reg         reset_n_i = 1'b0;
   reg         srst = 1'b0, en = 1'b0, sta = 1'b0, sto = 1'b0, thw = 1'b0, rhr = 1'b0;
   reg         rdsel = 1'b0;
   reg  [6:0]  device_address_field = 7'h50;
   reg  [6:0]  sadr = 7'h50;
   reg  [1:0]  iasz = 2'b00;
   reg  [23:0] internal_address_value = 24'h123456;
   reg  [7:0]  thd = 8'h00;
   wire        scl_oe, sda_oe, sda_oe_s, no_ack_flag, txr, rxr, txc;
   wire [7:0]  rhd;
   wire        scl_w = !scl_oe;
   wire        sda_w = !(sda_oe | sda_oe_s);
   wire [3:0]  fl = {i_slv.cnt == 1, rxr === 1'b1, txr === 1'b1, txc === 1'b1};
   integer     n_errors = 0, n_checks = 0, k, i, t;
   always #5 sys_clk_i = ~sys_clk_i;
   twbm_master i_dut (
      .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .soft_reset_i(srst),
      .master_enable_i(en), .master_disable_i(1'b0), .start_cmd_i(sta), .stop_cmd_i(sto),
      .read_direction_select_i(rdsel), .device_address_field_i(device_address_field),
      .internal_address_size_i(iasz), .internal_address_value_i(internal_address_value),
      .low_phase_divider_i(8'h02), .high_phase_divider_i(8'h02),
      .phase_prescale_exponent_i(3'h1), .transmit_holding_wr_i(thw),
      .transmit_holding_i(thd), .receive_holding_rd_i(rhr),
      .serial_clock_line_i(scl_w), .serial_data_line_i(sda_w),
      .serial_clock_line_o(), .serial_clock_line_oe_o(scl_oe), .serial_data_line_o(),
      .serial_data_line_oe_o(sda_oe), .receive_holding_o(rhd), .no_ack_flag_o(no_ack_flag),
      .tx_holding_ready_o(txr), .rx_holding_ready_o(rxr), .transfer_complete_flag_o(txc));
   twbm_slave_model i_slv (.scl_i(scl_w), .sda_i(sda_w), .dev_addr_i(sadr),
      .rd_base_i(8'hc0), .sda_oe_o(sda_oe_s));
   task summarize;
      begin
         $display("checks %0d errors %0d", n_checks, n_errors);
         if (n_errors == 0 && n_checks > 0) $display("RESULT: PASS");
         else $display("RESULT: FAIL");
         $finish;
      end
   endtask
   // Strobes {soft reset, enable, start, stop, holding write, holding read}.
   task pulse(input [5:0] v);
      begin
         @(negedge sys_clk_i);
         {srst, en, sta, sto, thw, rhr} = v;
         @(negedge sys_clk_i);
         {srst, en, sta, sto, thw, rhr} = 6'h00;
      end
   endtask
   // Waits for done, tx ready, rx ready or the slave's first bit of a byte.
   task waitf(input [1:0] s);
      begin
         repeat (3) @(negedge sys_clk_i);
         for (t = 0; t < 5000 && !fl[s]; t = t + 1) @(negedge sys_clk_i);
         if (t == 5000) begin
            n_errors = n_errors + 1;
            $display("[ERR] wait %0d timed out", s);
            summarize;
         end
      end
   endtask
   initial begin
      repeat (20) @(negedge sys_clk_i);
      reset_n_i = 1'b1;
      `CHK("tx_holding_ready", 1'b1, txr)
      `CHK("transfer_complete_flag", 1'b1, txc)
      `CHK("no_ack_flag", 1'b0, no_ack_flag)
      `CHK("rx_holding_ready", 1'b0, rxr)
      `CHK("rhr", 8'h00, rhd)
      $display("test reset done");
      pulse(6'h10);
      for (k = 0; k < 4; k = k + 1) begin
         iasz = k[1:0];
         i_slv.n_wr = 0;
         thd = 8'h3c;
         pulse(6'h02);
         waitf(1);
         thd = 8'h81;
         pulse(6'h02);
         waitf(0);
         `CHK("wr count", k + 3, i_slv.n_wr)
         `CHK("wr addr", 8'ha0, i_slv.wr_log[0])
         for (i = 1; i <= k; i = i + 1) `CHK("internal_address_value", internal_address_value[8*(k-i) +: 8], i_slv.wr_log[i])
         `CHK("wr d0", 8'h3c, i_slv.wr_log[k+1])
         `CHK("wr d1", 8'h81, i_slv.wr_log[k+2])
      end
      $display("test write done");
      sadr = 7'h7a;
      device_address_field = 7'h7a;
      iasz = 2'b01;
      internal_address_value = 24'h00005a;
      rdsel = 1'b1;
      i_slv.n_wr = 0;
      pulse(6'h0c);
      waitf(0);
      `CHK("rd log0", 8'hf4, i_slv.wr_log[0])
      `CHK("rd log1", 8'h5a, i_slv.wr_log[1])
      `CHK("rd log2", 8'hf5, i_slv.wr_log[2])
      `CHK("rd count", 1, i_slv.n_rd)
      `CHK("rd mack", 1'b0, i_slv.mack)
      `CHK("rd rhr", 8'hc0, rhd)
      pulse(6'h01);
      @(negedge sys_clk_i);
      `CHK("rd rx_holding_ready", 1'b0, rxr)
      $display("test single read done");
      sadr = 7'h50;
      device_address_field = 7'h50;
      iasz = 2'b00;
      i_slv.n_rd = 0;
      pulse(6'h08);
      for (i = 0; i < 3; i = i + 1) begin
         waitf(2);
         `CHK("rx byte", 8'hc0 + i, {24'h0, rhd})
         pulse(6'h01);
         if (i == 1) begin
            waitf(3);
            pulse(6'h04);
         end
      end
      waitf(0);
      `CHK("rx count", 3, i_slv.n_rd)
      `CHK("rx last", 1'b0, i_slv.mack)
      $display("test multi read done");
      device_address_field = 7'h33;
      for (k = 1; k >= 0; k = k - 1) begin
         rdsel = k[0];
         pulse(k ? 6'h08 : 6'h02);
         waitf(0);
         repeat (20) @(negedge sys_clk_i);
         `CHK("no_ack_flag", 1'b1, no_ack_flag)
         `CHK("no_ack_flag idle", 1'b1, txc)
      end
      pulse(6'h20);
      @(negedge sys_clk_i);
      `CHK("srst no_ack_flag", 1'b0, no_ack_flag)
      `CHK("srst tx_holding_ready", 1'b1, txr)
      `CHK("starts", 9, i_slv.n_start)
      `CHK("stops", 8, i_slv.n_stop)
      $display("test no_ack_flag done");
      summarize;
   end
endmodule
bind twbm_master twbm_chk i_chk (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
   .soft_reset_i(soft_reset_i), .transmit_holding_wr_i(transmit_holding_wr_i),
   .receive_holding_rd_i(receive_holding_rd_i), .serial_clock_line_o(serial_clock_line_o),
   .serial_clock_line_oe_o(serial_clock_line_oe_o), .serial_data_line_o(serial_data_line_o),
   .serial_data_line_oe_o(serial_data_line_oe_o), .rx_holding_ready_o(rx_holding_ready_o),
   .tx_holding_ready_o(tx_holding_ready_o),
   .transfer_complete_flag_o(transfer_complete_flag_o));
